// ==== rtl/capture_compare_pkg.sv ====
package capture_compare_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] value_low_off    = 8'h00;
  localparam logic [7:0] value_high_off   = 8'h04;
  localparam logic [7:0] unit_control_off = 8'h08;
  localparam logic [7:0] event_status_off = 8'h0c;
  localparam logic [7:0] timer_select_off = 8'h10;
  localparam logic [7:0] route_config_off = 8'h14;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int          mode_lsb          = 0;
  localparam int          duty_lsb          = 4;
  localparam logic [7:0]  control_mask      = 8'h3f;
  localparam logic [7:0]  control_reset     = 8'h00;
  localparam logic [15:0] value_reset       = 16'h0000;
  localparam logic [3:0]  presc_four_wrap   = 4'h3;
  localparam logic [3:0]  presc_sixteen_wrap = 4'hf;
  localparam logic        route_reset       = 1'b1;

  // ************************************************************
  // mode codes
  // ************************************************************
  localparam logic [3:0] mode_off          = 4'h0;
  localparam logic [3:0] mode_cmp_toggle   = 4'h2;
  localparam logic [3:0] mode_cap_fall     = 4'h4;
  localparam logic [3:0] mode_cap_rise     = 4'h5;
  localparam logic [3:0] mode_cap_rise4    = 4'h6;
  localparam logic [3:0] mode_cap_rise16   = 4'h7;
  localparam logic [3:0] mode_cmp_set_high = 4'h8;
  localparam logic [3:0] mode_cmp_set_low  = 4'h9;
  localparam logic [3:0] mode_cmp_soft     = 4'ha;
  localparam logic [3:0] mode_cmp_special  = 4'hb;

  typedef enum logic [1:0] {
    cls_off,
    cls_capture,
    cls_compare,
    cls_pwm
  } mode_class_e;

  // pin group carried to the two possible pins
  typedef struct packed {
    logic default_route_pin_out;
    logic default_route_pin_oe;
    logic alternate_route_pin_out;
    logic alternate_route_pin_oe;
  } pin_drive_s;

  typedef struct packed {
    logic        start_conversion;
    logic        reset_first;
    logic        reset_third;
  } trigger_s;

endpackage

// ==== rtl/capture_compare_unit.sv ====
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - value kept as separately addressable low and high bytes, read/write
// - mode 0000 disables and resets unit; 0001 and 0011 do nothing
// - mode 0010 toggles output and sets event flag on each match
// - mode 0100 captures falling edges, 0101 rising edges
// - mode 0110 captures every 4th rising edge, 0111 every 16th
// - mode 1000 drives output low, match forces high and sets flag
// - mode 1001 drives output high, match forces low and sets flag
// - mode 1010 only sets flag on match; pin follows port latch
// - mode 1011 match sets flag, resets time base, requests conversion
// - modes 11xx are pwm; control bits 5-4 and low byte form duty
// - capture/compare use first or third timer; pwm uses second timer
// - timer choice comes from timer select bits; units may share
// - capture copies full 16-bit selected timer into value pair
// - capture sets event flag; only software clears it
// - new capture overwrites stored value; no overrun indication
// - edges taken from pin level regardless of pin direction
// - prescaler cleared when unit off or capture mode left
// - switching prescaler codes keeps counter and may set flag
// - route bit 1 selects default pin, 0 alternate pin
// - both pwm units share second timer, same frequency and update
// - compare value register against selected timer every cycle
// - special event resets the timer used as time base
// - writing zero to control forces compare latch low
module capture_compare_unit
  import capture_compare_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timers
  input  wire logic [15:0] time_base_first,
  input  wire logic [15:0] time_base_third,
  input  wire logic [7:0]  pwm_time_base,
  input  wire logic        pwm_period_event,
  // pins and port latches
  input  wire logic        default_route_pin_in,
  input  wire logic        alternate_route_pin_in,
  input  wire logic        default_port_latch,
  input  wire logic        alternate_port_latch,
  input  wire logic        default_pin_direction_bit,
  input  wire logic        alternate_pin_direction_bit,
  output capture_compare_pkg::pin_drive_s pins,
  // triggers
  output capture_compare_pkg::trigger_s   triggers,
  output logic             event_flag,
  output logic [9:0]       pwm_duty_active
);

  import capture_compare_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] value;
    logic [7:0]  control;
    logic        flag;
    logic        use_third;
    logic        route_default;
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic [3:0]  presc;
    logic        cmp_latch;
    logic        matched;
    logic [9:0]  duty;
    logic        pwm_out;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    pin_drive_s  pin;
    trigger_s    trig;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  logic [3:0]  mode;
  mode_class_e cls;
  logic [15:0] sel_timer;
  logic        rise;
  logic        fall;
  logic        cap_event;
  logic        match;
  logic        setup;
  logic        wr_ctl;
  logic [3:0]  new_mode;
  logic        drive_unit;
  logic        unit_level;
  logic [9:0]  pwm_count;

  assign mode      = state_r.control[mode_lsb +: 4];
  assign sel_timer = state_r.use_third ? time_base_third : time_base_first;
  assign rise      = state_r.sync2 & ~state_r.sync3;
  assign fall      = ~state_r.sync2 & state_r.sync3;
  assign match     = (cls == cls_compare) && (state_r.value == sel_timer);
  assign setup     = psel & ~penable;
  assign pwm_count = {pwm_time_base, 2'b00};

  always_comb
  begin
    case (mode)
      mode_cap_fall, mode_cap_rise, mode_cap_rise4, mode_cap_rise16: cls = cls_capture;
      mode_cmp_toggle, mode_cmp_set_high, mode_cmp_set_low,
      mode_cmp_soft, mode_cmp_special: cls = cls_compare;
      4'hc, 4'hd, 4'he, 4'hf: cls = cls_pwm;
      default: cls = cls_off;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    state_nxt  = state_r;
    cap_event  = 1'b0;
    wr_ctl     = 1'b0;
    new_mode   = mode;
    drive_unit = 1'b0;
    unit_level = 1'b0;
    // routed pin level, whatever its direction
    state_nxt.sync1 = state_r.route_default ? default_route_pin_in : alternate_route_pin_in;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.sync3 = state_r.sync2;
    state_nxt.trig  = '0;

    // capture events
    case (mode)
      mode_cap_fall: cap_event = fall;
      mode_cap_rise: cap_event = rise;
      mode_cap_rise4:
      begin
        if (rise)
        begin
          cap_event = (state_r.presc[1:0] == presc_four_wrap[1:0]);
          state_nxt.presc = (state_r.presc[1:0] == presc_four_wrap[1:0]) ?
                            4'h0 : state_r.presc + 4'h1;
        end
      end
      mode_cap_rise16:
      begin
        if (rise)
        begin
          cap_event = (state_r.presc == presc_sixteen_wrap);
          state_nxt.presc = state_r.presc + 4'h1;
        end
      end
      default: state_nxt.presc = 4'h0;
    endcase
    if (cap_event)
    begin
      state_nxt.value = sel_timer;
    end

    // compare actions, match fires once per equality run
    state_nxt.matched = match;
    if (match && !state_r.matched)
    begin
      case (mode)
        mode_cmp_toggle:   state_nxt.cmp_latch = ~state_r.cmp_latch;
        mode_cmp_set_high: state_nxt.cmp_latch = 1'b1;
        mode_cmp_set_low:  state_nxt.cmp_latch = 1'b0;
        mode_cmp_special:
        begin
          state_nxt.trig.start_conversion = 1'b1;
          state_nxt.trig.reset_first      = ~state_r.use_third;
          state_nxt.trig.reset_third      = state_r.use_third;
        end
        default: state_nxt.cmp_latch = state_r.cmp_latch;
      endcase
    end

    // pwm: duty reloads at the shared period event
    if (pwm_period_event)
    begin
      state_nxt.duty = {state_r.value[7:0], state_r.control[duty_lsb +: 2]};
    end
    state_nxt.pwm_out = (cls == cls_pwm) && (pwm_count < state_r.duty);

    // apb slave, zero wait states
    state_nxt.ready  = 1'b0;
    state_nxt.slverr = 1'b0;
    if (setup)
    begin
      state_nxt.ready = 1'b1;
      case (paddr)
        value_low_off:    state_nxt.rdata = {24'h0, state_r.value[7:0]};
        value_high_off:   state_nxt.rdata = {24'h0, state_r.value[15:8]};
        unit_control_off: state_nxt.rdata = {24'h0, state_r.control};
        event_status_off: state_nxt.rdata = {31'h0, state_r.flag};
        timer_select_off: state_nxt.rdata = {31'h0, state_r.use_third};
        route_config_off: state_nxt.rdata = {31'h0, state_r.route_default};
        default:
        begin
          state_nxt.rdata  = 32'h0;
          state_nxt.slverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && state_r.ready && pwrite)
    begin
      case (paddr)
        value_low_off:  state_nxt.value[7:0]  = pwdata[7:0];
        value_high_off: state_nxt.value[15:8] = pwdata[7:0];
        unit_control_off:
        begin
          wr_ctl            = 1'b1;
          new_mode          = pwdata[3:0];
          state_nxt.control = pwdata[7:0] & control_mask;
        end
        event_status_off: if (pwdata[0]) state_nxt.flag = 1'b0;
        timer_select_off: state_nxt.use_third     = pwdata[0];
        route_config_off: state_nxt.route_default = pwdata[0];
        default: state_nxt.slverr = 1'b0;
      endcase
    end
    if (wr_ctl)
    begin
      if (new_mode == mode_off)
      begin
        state_nxt.cmp_latch = 1'b0;
        state_nxt.presc     = 4'h0;
        state_nxt.matched   = 1'b0;
      end
      else if (new_mode == mode_cmp_set_high)
      begin
        state_nxt.cmp_latch = 1'b0;
      end
      else if (new_mode == mode_cmp_set_low)
      begin
        state_nxt.cmp_latch = 1'b1;
      end
      if (new_mode[3:2] != 2'b01)
      begin
        state_nxt.presc = 4'h0;
      end
      // prescaler to prescaler change keeps the count
    end

    // set wins over software clear
    if (cap_event || (match && !state_r.matched))
    begin
      state_nxt.flag = 1'b1;
    end

    // pin drive
    case (cls)
      cls_compare:
      begin
        drive_unit = (mode != mode_cmp_soft);
        unit_level = state_r.cmp_latch;
      end
      cls_pwm:
      begin
        drive_unit = 1'b1;
        unit_level = state_r.pwm_out;
      end
      default: drive_unit = 1'b0;
    endcase
    state_nxt.pin.default_route_pin_out   = (drive_unit && state_r.route_default) ?
                                            unit_level : default_port_latch;
    state_nxt.pin.default_route_pin_oe    = ~default_pin_direction_bit;
    state_nxt.pin.alternate_route_pin_out = (drive_unit && !state_r.route_default) ?
                                            unit_level : alternate_port_latch;
    state_nxt.pin.alternate_route_pin_oe  = ~alternate_pin_direction_bit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r               <= '0;
      state_r.control       <= control_reset;
      state_r.value         <= value_reset;
      state_r.route_default <= route_reset;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
    end
  end

  assign prdata          = state_r.rdata;
  assign pready          = state_r.ready;
  assign pslverr         = state_r.slverr;
  assign pins            = state_r.pin;
  assign triggers        = state_r.trig;
  assign event_flag      = state_r.flag;
  assign pwm_duty_active = state_r.duty;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  capture_copies_a: assert property (
      clk_en && cap_event |=> state_r.value == $past(sel_timer))
    else $error("capture did not copy timer");
  capture_flags_a: assert property (
      clk_en && cap_event |=> state_r.flag)
    else $error("capture did not set flag");
  // gated by the enable: a frozen clock stretches every pulse
  special_pulse_a: assert property (
      clk_en && triggers.start_conversion |=> !triggers.start_conversion)
    else $error("conversion start longer than a cycle");
  special_flag_a: assert property (
      triggers.start_conversion |-> event_flag)
    else $error("special event without flag");
  special_reset_a: assert property (
      triggers.start_conversion |-> (triggers.reset_third == state_r.use_third)
      && (triggers.reset_first != state_r.use_third))
    else $error("wrong timer reset");
  off_clears_presc_a: assert property (
      clk_en && cls == cls_off |=> state_r.presc == 4'h0)
    else $error("prescaler kept while off");
  zero_latch_a: assert property (
      clk_en && wr_ctl && new_mode == mode_off |=> !state_r.cmp_latch)
    else $error("compare latch not cleared");
  soft_pin_a: assert property (
      clk_en && mode == mode_cmp_soft && state_r.route_default
      |=> pins.default_route_pin_out == $past(default_port_latch))
    else $error("soft mode drove pin");
  toggle_a: assert property (
      clk_en && mode == mode_cmp_toggle && match && !state_r.matched && !wr_ctl
      |=> state_r.cmp_latch != $past(state_r.cmp_latch))
    else $error("toggle missed");

  // ************************************************************
  // compare, flag, register write and pin assertions
  // ************************************************************
  set_high_a: assert property (
      clk_en && mode == mode_cmp_set_high && match && !state_r.matched && !wr_ctl
      |=> state_r.cmp_latch)
    else $error("match did not force latch high");
  set_low_a: assert property (
      clk_en && mode == mode_cmp_set_low && match && !state_r.matched && !wr_ctl
      |=> !state_r.cmp_latch)
    else $error("match did not force latch low");
  compare_flag_a: assert property (
      clk_en && match && !state_r.matched |=> state_r.flag)
    else $error("match did not set flag");
  // only a software write to the status word may drop the flag
  flag_sticky_a: assert property (
      clk_en && state_r.flag
      && !(psel && penable && pready && pwrite && paddr == event_status_off)
      |=> state_r.flag)
    else $error("flag dropped by hardware");
  value_write_a: assert property (
      clk_en && psel && penable && pready && pwrite && paddr == value_low_off
      |=> state_r.value[7:0] == $past(pwdata[7:0]))
    else $error("low value byte not written");
  pwm_drive_a: assert property (
      clk_en && cls == cls_pwm && state_r.route_default
      |=> pins.default_route_pin_out == $past(state_r.pwm_out))
    else $error("pwm output not on default pin");
  route_alt_a: assert property (
      clk_en && cls == cls_pwm && !state_r.route_default
      |=> pins.alternate_route_pin_out == $past(state_r.pwm_out))
    else $error("pwm output not on alternate pin");

  rise_cap_c: cover property (mode == mode_cap_rise && cap_event);
  div16_cap_c: cover property (mode == mode_cap_rise16 && cap_event);
  special_c: cover property (triggers.start_conversion);
  pwm_c: cover property (cls == cls_pwm && pins.default_route_pin_out);
  toggle_c: cover property (mode == mode_cmp_toggle && match && !state_r.matched);

endmodule

// ==== test/cc_far_side.sv ====
`timescale 1ns/1ps
// ************************************************************
// timers seen by the unit
// ************************************************************
// first held at preset, third at its inverse, while stopped so the bench knows what a capture sees
module cc_far_side
  import capture_compare_pkg::*;
(
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // bench control
  input  wire logic                            run,
  input  wire logic [15:0]                     preset,
  input  wire capture_compare_pkg::trigger_s   triggers,
  // timer values
  output logic      [15:0]                     time_base_first,
  output logic      [15:0]                     time_base_third
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      time_base_first <= 16'h0000;
      time_base_third <= 16'h0000;
    end
    else if (!run)
    begin
      time_base_first <= preset;
      time_base_third <= ~preset;
    end
    else
    begin
      time_base_first <= triggers.reset_first ? 16'h0000 : time_base_first + 16'h0001;
      time_base_third <= triggers.reset_third ? 16'h0000 : time_base_third + 16'h0001;
    end
  end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  import capture_compare_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, event_flag, run = 0, pin = 0, ppe = 0;
  logic        latch = 1, dir = 0, ce = 1;
  logic [15:0] preset = 0, tbf, tbt;
  logic [9:0]  duty;
  pin_drive_s  pins;
  trigger_s    trig;
  int          n_errors = 0, n_tests = 0, cyc = 0, n;
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rw[6] = '{32'h1a5, 32'h1c3, 32'hff, 32'h1, 32'hff, 32'hfe};
  logic [31:0] r0[6] = '{0, 0, 0, 0, 0, 1};
  logic [31:0] r1[6] = '{32'ha5, 32'hc3, 32'h3f, 0, 1, 0};
  logic [3:0]  cm[4] = '{4'h8, 4'h2, 4'h9, 4'ha};
  logic        c0[4] = '{0, 0, 1, 1};
  logic        c1[4] = '{1, 1, 0, 1};

  always #25 pclk = ~pclk;

  capture_compare_unit u_capture_compare_unit (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .time_base_first(tbf),
    .time_base_third(tbt), .pwm_time_base(8'h00), .pwm_period_event(ppe),
    .default_route_pin_in(pin), .alternate_route_pin_in(1'b0), .default_port_latch(latch),
    .alternate_port_latch(1'b0), .default_pin_direction_bit(dir),
    .alternate_pin_direction_bit(1'b1), .pins(pins), .triggers(trig),
    .event_flag(event_flag), .pwm_duty_active(duty));

  cc_far_side u_cc_far_side (.pclk(pclk), .presetn(presetn), .run(run), .preset(preset),
    .triggers(trig), .time_base_first(tbf), .time_base_third(tbt));

  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task automatic results();
    $display("errors=%0d checks=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // one pwm period event, then time for duty and pin to settle
  task automatic ppulse();
    @(posedge pclk);
    ppe <= 1'b1;
    @(posedge pclk);
    ppe <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // high for three cycles and low for six, each outlasting the input synchroniser
  task automatic pulse();
    @(posedge pclk);
    pin <= 1'b1;
    repeat (3) @(posedge pclk);
    pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // ************************************************************
    // register table: reset value, then write and read back
    // ************************************************************
    for (int i = 0; i < 6; i++)
    begin
      rdchk(ra[i], r0[i]);
      apb(1'b1, ra[i], rw[i]);
      rdchk(ra[i], r1[i]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1);
    chk(rd, 0);
    apb(1'b1, 8'h08, 0);
    apb(1'b1, 8'h10, 0);
    apb(1'b1, 8'h14, 1);
    // ************************************************************
    // capture edges, overwrite, timer choice, prescalers
    // ************************************************************
    preset <= 16'h1234;
    apb(1'b1, 8'h08, 5);
    apb(1'b1, 8'h0c, 1);
    pulse();
    rdchk(8'h00, 32'h34);
    rdchk(8'h04, 32'h12);
    rdchk(8'h0c, 1);
    preset <= 16'h5678;
    pulse();
    rdchk(8'h00, 32'h78);
    apb(1'b1, 8'h10, 1);
    apb(1'b1, 8'h08, 4);
    preset <= 16'h0f0f;
    pulse();
    rdchk(8'h04, 32'hf0);
    apb(1'b1, 8'h10, 0);
    dir <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      n = k ? 16 : 4;
      apb(1'b1, 8'h08, 0);
      apb(1'b1, 8'h08, 6 + k);
      apb(1'b1, 8'h0c, 1);
      preset <= 16'(n);
      for (int i = 1; i <= n; i++)
      begin
        pulse();
        chk(event_flag, i == n);
      end
      rdchk(8'h00, n);
    end
    // two counts taken in the divide-by-16 code must survive a direct switch
    pulse();
    pulse();
    apb(1'b1, 8'h08, 6);
    apb(1'b1, 8'h0c, 1);
    pulse();
    chk(event_flag, 0);
    pulse();
    chk(event_flag, 1);
    // ************************************************************
    // compare pin actions
    // ************************************************************
    dir <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      preset <= 16'h0000;
      apb(1'b1, 8'h08, 0);
      apb(1'b1, 8'h00, 32'h44);
      apb(1'b1, 8'h04, 0);
      apb(1'b1, 8'h08, cm[i]);
      apb(1'b1, 8'h0c, 1);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(pins.default_route_pin_out, c0[i]);
      chk({pins.default_route_pin_oe, event_flag}, 2'b10);
      @(posedge pclk);
      preset <= 16'h0044;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk({pins.default_route_pin_out, event_flag}, {c1[i], 1'b1});
    end
    // ************************************************************
    // special event trigger
    // ************************************************************
    // reserved codes act as off even while the timer sits on the compare value
    for (int m = 1; m < 4; m += 2)
    begin
      apb(1'b1, 8'h08, 0);
      apb(1'b1, 8'h08, m);
      apb(1'b1, 8'h0c, 1);
      repeat (3) @(posedge pclk);
      chk(event_flag, 0);
    end
    preset <= 16'h0000;
    apb(1'b1, 8'h08, 0);
    apb(1'b1, 8'h00, 32'h20);
    apb(1'b1, 8'h08, 4'hb);
    apb(1'b1, 8'h0c, 1);
    run <= 1'b1;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (trig.reset_first !== 1'b1 && n < 100);
    chk({trig, event_flag}, 4'b1101);
    @(negedge pclk);
    chk({trig, tbf}, 19'h0);
    run <= 1'b0;
    // ************************************************************
    // pwm duty load, routing, enable, then a second reset
    // ************************************************************
    apb(1'b1, 8'h00, 32'h5a);
    apb(1'b1, 8'h08, 32'h3c);
    ppulse();
    chk(duty, {8'h5a, 2'b11});
    @(negedge pclk);
    chk(pins.default_route_pin_out, 1);
    latch <= 1'b0;
    apb(1'b1, 8'h14, 0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(pins, 4'b0110);
    apb(1'b1, 8'h08, 32'h0c);
    ce <= 1'b0;
    ppulse();
    chk(duty, {8'h5a, 2'b11});
    ce <= 1'b1;
    ppulse();
    chk(duty, {8'h5a, 2'b00});
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(event_flag, 0);
    rdchk(8'h08, 0);
    rdchk(8'h14, 1);
    results();
  end
endmodule
